// file: ebpm_pkg.sv
// Purpose: Shared constants and types for the external bus pin mux
// Assumes: 32-bit APB data, byte addresses on an 8-bit address bus
// Notes:   Pin index order of the control pin group is fixed here
package ebpm_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_FUNC     = 8'h04;
   localparam logic [7:0] OFS_LANE_OUT = 8'h08;
   localparam logic [7:0] OFS_LANE_DIR = 8'h0C;
   localparam logic [7:0] OFS_MISC_OUT = 8'h10;
   localparam logic [7:0] OFS_MISC_DIR = 8'h14;
   localparam logic [7:0] OFS_LANE_IN  = 8'h18;
   localparam logic [7:0] OFS_MISC_IN  = 8'h1C;
   localparam logic [7:0] OFS_STATUS   = 8'h20;

   // Pin group widths
   localparam int unsigned LANE_W = 24;
   localparam int unsigned MISC_W = 10;
   localparam int unsigned FUNC_W = 9;
   localparam int unsigned PAD_W  = LANE_W + MISC_W;
   localparam int unsigned DATA_W = 32;

   // Control pin group: index of each pin
   localparam int unsigned MP_READY   = 0;
   localparam int unsigned MP_GRANT   = 1;
   localparam int unsigned MP_REQUEST = 2;
   localparam int unsigned MP_WSTR2   = 3;
   localparam int unsigned MP_WSTR1   = 4;
   localparam int unsigned MP_WSTR0   = 5;
   localparam int unsigned MP_SYSTEM_CLOCK_OUT  = 6;
   localparam int unsigned MP_MCLKEN  = 7;
   localparam int unsigned MP_MCLK    = 8;
   localparam int unsigned MP_SPARE   = 9;

   typedef enum logic [1:0] {
      WIDTH_8  = 2'b00,
      WIDTH_16 = 2'b01,
      WIDTH_32 = 2'b10,
      WIDTH_RS = 2'b11
   } ebpm_width_e;

   typedef struct packed {
      logic        sdram;
      logic        common_strobe;
      ebpm_width_e width;
   } ebpm_ctrl_s;

   // Bit i enables the bus function of control pin i
   typedef struct packed {
      logic mclk;
      logic mclken;
      logic system_clock_out;
      logic wstr0;
      logic wstr1;
      logic wstr2;
      logic request;
      logic grant;
      logic ready;
   } ebpm_func_s;

   typedef struct packed {
      logic o;
      logic oe;
   } ebpm_pad_s;

   // Reset values
   localparam ebpm_ctrl_s       CTRL_RST     = '{sdram: 1'b0,
                                                 common_strobe: 1'b0,
                                                 width: WIDTH_32};
   localparam logic [FUNC_W-1:0] FUNC_RST    = 9'h000;
   localparam logic [LANE_W-1:0] LANE_RST    = 24'h000000;
   localparam logic [MISC_W-1:0] MISC_RST    = 10'h000;
   localparam logic [DATA_W-1:0] RDATA_RST   = 32'h00000000;

endpackage

// file: ebpm_sync.sv
// Purpose: Multi-bit two-flop synchroniser for pin inputs
// Assumes: Bits are independent levels, no word coherence needed
// Notes:   First stage feeds only the next stage
`timescale 1ns/1ps
`default_nettype none
module ebpm_sync #(
   parameter int unsigned WIDTH  = 1,
   parameter int unsigned STAGES = 2
) (
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // Data
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] stage [STAGES];

   if (STAGES < 2 || WIDTH < 1) begin : g_bad
      $error("ebpm_sync needs at least two stages and one bit");
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < STAGES; i++) begin
            stage[i] <= '0;
         end
      end else begin
         stage[0] <= d;
         for (int i = 1; i < STAGES; i++) begin
            stage[i] <= stage[i-1];
         end
      end
   end

   assign q = stage[STAGES-1];
endmodule
`default_nettype wire

// file: ebpm_pad_mux.sv
// Purpose: One pin chooses between its bus function and its port
// Assumes: Select is stable per configuration
// Notes:   Purely combinational; pin drivers sit outside
`timescale 1ns/1ps
`default_nettype none
module ebpm_pad_mux
   import ebpm_pkg::*;
(
   // Selection
   input  wire logic      port_sel,
   // Bus function and port drive
   input  wire ebpm_pad_s bus_drv,
   input  wire ebpm_pad_s port_drv,
   // Pin drive
   output ebpm_pad_s      pad
);
   assign pad = port_sel ? port_drv : bus_drv;
endmodule
`default_nettype wire

// file: ebpm_top.sv
// Purpose: Pin function mux for the external bus pins, APB configured
// Assumes: Bus controller signals share pclk; pins are asynchronous
// Notes:   Pin levels are resolved outside from the o and oe pairs
// What this block does
// [RULE1] Data bits 0 to 15 become ports in 8-bit or 16-bit bus width.
// [RULE2] Data bits 16 to 23 become ports only in 8-bit bus width.
// [RULE3] Data bits 24 to 31 always carry the bus, never a port.
// [RULE4] Ready pin is a port when disabled, else sampled as bus ready.
// [RULE5] Grant acknowledge drives low while the bus is released, if enabled.
// [RULE6] Outside master drives request high; honoured only when enabled.
// [RULE7] Disabled grant acknowledge pin works as a port.
// [RULE8] Disabled release request pin works as a port.
// [RULE9] First write strobe is byte enable or mask for bits 31 to 24.
// [RULE10] Second write strobe is byte enable or mask for bits 23 to 16.
// [RULE11] Third write strobe is byte enable or mask for bits 15 to 8.
// [RULE12] Fourth write strobe is byte enable or mask for bits 7 to 0.
// [RULE13] Disabled second, third or fourth write strobe pin is a port.
// [RULE14] System clock out runs at bus rate when enabled, halts in stop.
// [RULE15] Memory clock out runs at bus rate when enabled, halts in sleep.
// [RULE16] Disabled system clock pin works as a port.
// [RULE17] Memory clock enable pin drives the enable, or is a port.
// [RULE18] Disabled memory clock pin works as a port.
// [RULE19] Port pins follow direction and data registers, not bus activity.
`timescale 1ns/1ps
`default_nettype none
module ebpm_top
   import ebpm_pkg::*;
#(
   parameter int unsigned SYNC_STAGES = 2
) (
   // APB slave
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [DATA_W-1:0] pwdata,
   output logic      [DATA_W-1:0] prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Bus controller side
   input  wire logic [DATA_W-1:0] bus_data_o,
   input  wire logic              bus_data_oe,
   output logic      [DATA_W-1:0] bus_data_i,
   output logic                   bus_ready,
   output logic                   bus_release_req,
   input  wire logic              bus_released,
   input  wire logic              read_strobe_n,
   input  wire logic [3:0]        write_strobe_n,
   input  wire logic [3:0]        byte_enable_n,
   input  wire logic [3:0]        sdram_mask,
   input  wire logic              mclken_value,
   input  wire logic              stop_mode,
   input  wire logic              sleep_mode,
   // Data lane pins, lane 0 in the low byte
   input  wire logic [DATA_W-1:0] data_pins_i,
   output logic      [DATA_W-1:0] data_pins_o,
   output logic      [DATA_W-1:0] data_pins_oe,
   // Control pins, indexed by MP_* constants
   input  wire logic [MISC_W-1:0] misc_pins_i,
   output logic      [MISC_W-1:0] misc_pins_o,
   output logic      [MISC_W-1:0] misc_pins_oe,
   // Dedicated output pins
   output logic                   read_strobe_pin,
   output logic                   write_strobe_lane3
);
   ebpm_ctrl_s        ctrl;
   ebpm_func_s        func;
   logic [LANE_W-1:0] lane_out;
   logic [LANE_W-1:0] lane_dir;
   logic [MISC_W-1:0] misc_out;
   logic [MISC_W-1:0] misc_dir;
   logic [DATA_W-1:0] sync_data;
   logic [MISC_W-1:0] sync_misc;
   logic [DATA_W-1:0] next_prdata;
   logic              next_pslverr;
   logic              setup_ph;
   logic              wr_en;
   logic [2:0]        lane_port;
   logic [3:0]        strobe_val;
   logic              system_clock_out_q;
   logic              mclk_q;
   logic [PAD_W-1:0]  pad_sel;
   ebpm_pad_s         bus_drv  [PAD_W];
   ebpm_pad_s         port_drv [PAD_W];
   ebpm_pad_s         pad      [PAD_W];

   function automatic logic is_port_lane(ebpm_width_e w, int unsigned lane);
      logic r;
      r = 1'b0;
      if (lane < 2) begin
         r = (w == WIDTH_8) || (w == WIDTH_16);
      end else if (lane == 2) begin
         r = (w == WIDTH_8);
      end
      return r;
   endfunction

   function automatic logic addr_mapped(logic [7:0] a);
      return (a == OFS_CTRL) || (a == OFS_FUNC) || (a == OFS_LANE_OUT) ||
             (a == OFS_LANE_DIR) || (a == OFS_MISC_OUT) ||
             (a == OFS_MISC_DIR) || (a == OFS_LANE_IN) ||
             (a == OFS_MISC_IN) || (a == OFS_STATUS);
   endfunction

   // Pin inputs are asynchronous to pclk
   ebpm_sync #(
      .WIDTH  (DATA_W + MISC_W),
      .STAGES (SYNC_STAGES)
   ) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       ({misc_pins_i, data_pins_i}),
      .q       ({sync_misc, sync_data})
   );

   // APB: read data is captured in setup so the access needs no wait
   assign setup_ph = psel && !penable;
   assign wr_en    = psel && penable && pwrite && !pslverr;
   assign pready   = 1'b1;

   always_comb begin
      next_prdata = RDATA_RST;
      if (paddr == OFS_CTRL) begin
         next_prdata[3:0] = ctrl;
      end else if (paddr == OFS_FUNC) begin
         next_prdata[FUNC_W-1:0] = func;
      end else if (paddr == OFS_LANE_OUT) begin
         next_prdata[LANE_W-1:0] = lane_out;
      end else if (paddr == OFS_LANE_DIR) begin
         next_prdata[LANE_W-1:0] = lane_dir;
      end else if (paddr == OFS_MISC_OUT) begin
         next_prdata[MISC_W-1:0] = misc_out;
      end else if (paddr == OFS_MISC_DIR) begin
         next_prdata[MISC_W-1:0] = misc_dir;
      end else if (paddr == OFS_LANE_IN) begin
         next_prdata[LANE_W-1:0] = sync_data[LANE_W-1:0];
      end else if (paddr == OFS_MISC_IN) begin
         next_prdata[MISC_W-1:0] = sync_misc;
      end else if (paddr == OFS_STATUS) begin
         next_prdata[4:0] = {lane_port[2], lane_port[0], bus_released,
                             bus_release_req, bus_ready};
      end
      next_pslverr = !addr_mapped(paddr);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= RDATA_RST;
         pslverr <= 1'b0;
      end else if (setup_ph) begin
         prdata  <= pwrite ? RDATA_RST : next_prdata;
         pslverr <= next_pslverr;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= CTRL_RST;
      end else if (wr_en && paddr == OFS_CTRL) begin
         ctrl <= pwdata[3:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         func <= FUNC_RST;
      end else if (wr_en && paddr == OFS_FUNC) begin
         func <= pwdata[FUNC_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lane_out <= LANE_RST;
         lane_dir <= LANE_RST;
      end else if (wr_en && paddr == OFS_LANE_OUT) begin
         lane_out <= pwdata[LANE_W-1:0];
      end else if (wr_en && paddr == OFS_LANE_DIR) begin
         lane_dir <= pwdata[LANE_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         misc_out <= MISC_RST;
         misc_dir <= MISC_RST;
      end else if (wr_en && paddr == OFS_MISC_OUT) begin
         misc_out <= pwdata[MISC_W-1:0];
      end else if (wr_en && paddr == OFS_MISC_DIR) begin
         misc_dir <= pwdata[MISC_W-1:0];
      end
   end

   // Clock outputs: toggling at pclk/2 stands in for the bus clock;
   // halted clocks park low so the memory never sees a runt pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         system_clock_out_q <= 1'b0;
      end else begin
         system_clock_out_q <= (stop_mode || !func.system_clock_out) ? 1'b0 : !system_clock_out_q; // RULE14
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mclk_q <= 1'b0;
      end else begin
         mclk_q <= (sleep_mode || !func.mclk) ? 1'b0 : !mclk_q; // RULE15
      end
   end

   // Lane roles from bus width
   for (genvar l = 0; l < 3; l++) begin : g_lane
      if (l < 2) begin : g_low
         assign lane_port[l] = is_port_lane(ctrl.width, l); // RULE1
      end else begin : g_mid
         assign lane_port[l] = is_port_lane(ctrl.width, l); // RULE2
      end
   end

   // Strobe k drives lane 3-k: mask with SDRAM, byte enable with one WR
   for (genvar k = 0; k < 4; k++) begin : g_strobe
      assign strobe_val[k] = ctrl.sdram ? sdram_mask[k] :            // RULE9
                             ctrl.common_strobe ? byte_enable_n[k] : // RULE10
                             write_strobe_n[k];                      // RULE11
   end

   // Data lanes 0..2 through the pad mux
   for (genvar i = 0; i < LANE_W; i++) begin : g_lpad
      assign pad_sel[i]  = lane_port[i/8];
      assign bus_drv[i]  = '{o: bus_data_o[i], oe: bus_data_oe};
      assign port_drv[i] = '{o: lane_out[i], oe: lane_dir[i]}; // RULE19
   end

   // Control pins: spare is always a port
   assign pad_sel[LANE_W+MP_READY]   = !func.ready;   // RULE4
   assign pad_sel[LANE_W+MP_GRANT]   = !func.grant;   // RULE7
   assign pad_sel[LANE_W+MP_REQUEST] = !func.request; // RULE8
   assign pad_sel[LANE_W+MP_WSTR2]   = !func.wstr2;   // RULE13
   assign pad_sel[LANE_W+MP_WSTR1]   = !func.wstr1;   // RULE13
   assign pad_sel[LANE_W+MP_WSTR0]   = !func.wstr0;   // RULE13
   assign pad_sel[LANE_W+MP_SYSTEM_CLOCK_OUT]  = !func.system_clock_out;  // RULE16
   assign pad_sel[LANE_W+MP_MCLKEN]  = !func.mclken;  // RULE17
   assign pad_sel[LANE_W+MP_MCLK]    = !func.mclk;    // RULE18
   assign pad_sel[LANE_W+MP_SPARE]   = 1'b1;

   assign bus_drv[LANE_W+MP_READY]   = '{o: 1'b0, oe: 1'b0};
   assign bus_drv[LANE_W+MP_GRANT]   = '{o: !bus_released, oe: 1'b1}; // RULE5
   assign bus_drv[LANE_W+MP_REQUEST] = '{o: 1'b0, oe: 1'b0};
   assign bus_drv[LANE_W+MP_WSTR2]   = '{o: strobe_val[1], oe: 1'b1};
   assign bus_drv[LANE_W+MP_WSTR1]   = '{o: strobe_val[2], oe: 1'b1};
   assign bus_drv[LANE_W+MP_WSTR0]   = '{o: strobe_val[3], oe: 1'b1}; // RULE12
   assign bus_drv[LANE_W+MP_SYSTEM_CLOCK_OUT]  = '{o: system_clock_out_q, oe: 1'b1};
   assign bus_drv[LANE_W+MP_MCLKEN]  = '{o: mclken_value, oe: 1'b1}; // RULE17
   assign bus_drv[LANE_W+MP_MCLK]    = '{o: mclk_q, oe: 1'b1};
   assign bus_drv[LANE_W+MP_SPARE]   = '{o: 1'b0, oe: 1'b0};

   for (genvar j = 0; j < MISC_W; j++) begin : g_mdrv
      assign port_drv[LANE_W+j] = '{o: misc_out[j], oe: misc_dir[j]};
   end

   for (genvar p = 0; p < PAD_W; p++) begin : g_pad
      ebpm_pad_mux u_pad (
         .port_sel (pad_sel[p]),
         .bus_drv  (bus_drv[p]),
         .port_drv (port_drv[p]),
         .pad      (pad[p])
      );
      if (p < LANE_W) begin : g_lo
         assign data_pins_o[p]  = pad[p].o;
         assign data_pins_oe[p] = pad[p].oe;
      end else begin : g_mo
         assign misc_pins_o[p-LANE_W]  = pad[p].o;
         assign misc_pins_oe[p-LANE_W] = pad[p].oe;
      end
   end

   // Top lane has no port alternative
   assign data_pins_o[DATA_W-1:LANE_W]  = bus_data_o[DATA_W-1:LANE_W]; // RULE3
   assign data_pins_oe[DATA_W-1:LANE_W] = {8{bus_data_oe}};            // RULE3
   assign write_strobe_lane3 = strobe_val[0];                          // RULE9
   assign read_strobe_pin    = read_strobe_n;

   // Bus inputs; a disabled ready reads as always ready
   assign bus_data_i      = sync_data;
   assign bus_ready       = func.ready ? sync_misc[MP_READY] : 1'b1;      // RULE4
   assign bus_release_req = func.request && sync_misc[MP_REQUEST]; // RULE6

   // Checks
   sequence apb_wr_lane_s;
      psel && penable && pwrite && !pslverr && paddr == OFS_LANE_OUT;
   endsequence

   sequence stop_held_s;
      stop_mode [*2];
   endsequence

   lane3_bus_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
      data_pins_oe[31:24] == {8{bus_data_oe}} && data_pins_o[31:24] == bus_data_o[31:24])
      else $error("top lane left the bus");

   lane01_port_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
      (ctrl.width == WIDTH_16) |-> data_pins_oe[15:0] == lane_dir[15:0])
      else $error("low lanes not ports in 16-bit width");

   lane2_bus_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
      (ctrl.width == WIDTH_16) |-> data_pins_oe[23:16] == {8{bus_data_oe}})
      else $error("lane 2 left bus in 16-bit width");

   ready_in_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
      func.ready && $past(func.ready, 3) |-> bus_ready == $past(misc_pins_i[MP_READY], 2))
      else $error("ready not sampled through sync");

   grant_low_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
      func.grant && bus_released |-> !misc_pins_o[MP_GRANT] && misc_pins_oe[MP_GRANT])
      else $error("grant not low while released");

   req_gate_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
      !func.request |-> !bus_release_req &&
      misc_pins_oe[MP_REQUEST] == misc_dir[MP_REQUEST])
      else $error("disabled request still honoured");

   strobe_mask_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
      ctrl.sdram && func.wstr1 |-> misc_pins_o[MP_WSTR1] == sdram_mask[2])
      else $error("third strobe not lane 1 mask");

   system_clock_out_stop_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
      stop_held_s |-> !system_clock_out_q)
      else $error("system clock toggles in stop");

   system_clock_out_run_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
      func.system_clock_out && !stop_mode && $past(func.system_clock_out) && !$past(stop_mode)
      |-> system_clock_out_q != $past(system_clock_out_q))
      else $error("system clock not running");

   mclk_sleep_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE15
      sleep_mode [*2] |-> !mclk_q && (func.mclk ? !misc_pins_o[MP_MCLK] : 1'b1))
      else $error("memory clock toggles in sleep");

   port_follow_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE19
      apb_wr_lane_s ##1 (ctrl.width == WIDTH_8)
      |-> data_pins_o[LANE_W-1:0] == $past(pwdata[LANE_W-1:0]))
      else $error("port data not on pins after write");
endmodule
`default_nettype wire

// file: ebpm_pins_model.sv
// Purpose: Far side of the pins, resolving each pin from all its drivers
// Assumes: Outside devices drive every pin the block leaves undriven
// Notes:   No pulls, so a released pin takes the outside value
`timescale 1ns/1ps
`default_nettype none
module ebpm_pins_model
   import ebpm_pkg::*;
(
   // Block drive
   input  wire logic [DATA_W-1:0] data_o,
   input  wire logic [DATA_W-1:0] data_oe,
   input  wire logic [MISC_W-1:0] misc_o,
   input  wire logic [MISC_W-1:0] misc_oe,
   // Outside drive
   input  wire logic [DATA_W-1:0] ext_data,
   input  wire logic [MISC_W-1:0] ext_misc,
   // Pin levels
   output logic      [DATA_W-1:0] data_i,
   output logic      [MISC_W-1:0] misc_i
);
   // Outside parties only win where the block has let go of the pin
   assign data_i = (data_oe & data_o) | (~data_oe & ext_data);
   assign misc_i = (misc_oe & misc_o) | (~misc_oe & ext_misc);
endmodule
`default_nettype wire

// file: testbench.sv
// Purpose: Self-checking bench for the external bus pin mux
// Assumes: Zero wait APB slave, two-flop pin synchronisers
// Notes:   Checks on synchronised pin inputs wait three edges so they settle
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import ebpm_pkg::*;
   logic              pclk, presetn, psel, penable, pwrite;
   logic [7:0]        paddr;
   logic [DATA_W-1:0] pwdata, prdata, bus_data_o, bus_data_i;
   logic              pready, pslverr, bus_data_oe, bus_ready;
   logic              bus_release_req, bus_released, read_strobe_n;
   logic [3:0]        write_strobe_n, byte_enable_n, sdram_mask, sel;
   logic              mclken_value, stop_mode, sleep_mode;
   logic [DATA_W-1:0] data_pins_i, data_pins_o, data_pins_oe, ext_data;
   logic [MISC_W-1:0] misc_pins_i, misc_pins_o, misc_pins_oe, ext_misc;
   logic              read_strobe_pin, write_strobe_lane3, er, a6, a8;
   logic [31:0]       rd, lo, ld, bo, eo, eoe, mo, md;
   int                failures, tests_run;

   ebpm_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .bus_data_o(bus_data_o), .bus_data_oe(bus_data_oe),
      .bus_data_i(bus_data_i), .bus_ready(bus_ready),
      .bus_release_req(bus_release_req), .bus_released(bus_released),
      .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
      .byte_enable_n(byte_enable_n), .sdram_mask(sdram_mask),
      .mclken_value(mclken_value), .stop_mode(stop_mode),
      .sleep_mode(sleep_mode), .data_pins_i(data_pins_i),
      .data_pins_o(data_pins_o), .data_pins_oe(data_pins_oe),
      .misc_pins_i(misc_pins_i), .misc_pins_o(misc_pins_o),
      .misc_pins_oe(misc_pins_oe), .read_strobe_pin(read_strobe_pin),
      .write_strobe_lane3(write_strobe_lane3));

   ebpm_pins_model pins (.data_o(data_pins_o), .data_oe(data_pins_oe),
      .misc_o(misc_pins_o), .misc_oe(misc_pins_oe), .ext_data(ext_data),
      .ext_misc(ext_misc), .data_i(data_pins_i), .misc_i(misc_pins_i));

   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Request held unchanged until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         failures++;
         conclude();
      end else begin
         rd = prdata;
         er = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge pclk);
      @(negedge pclk);
   endtask

   function automatic logic lane_port(input logic [1:0] w, input int k);
      return (k < 2 && (w == WIDTH_8 || w == WIDTH_16)) ||
             (k == 2 && w == WIDTH_8);
   endfunction

   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {bus_data_o, bus_data_oe, bus_released, read_strobe_n} = '0;
      {write_strobe_n, byte_enable_n, sdram_mask, mclken_value} = '0;
      {stop_mode, sleep_mode, ext_data, ext_misc} = '0;
      failures = 0;
      tests_run = 0;
      presetn = 1'b0;
      void'($urandom(79817));
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, OFS_CTRL, 32'h0);
      chk(rd, {28'h0, CTRL_RST});
      apb(1'b0, 8'h40, 32'h0);
      chk({31'h0, er}, 32'h1);
      $display("reset and unmapped test done");
      for (int w = 0; w < 4; w++) begin
         lo = $urandom;
         ld = $urandom;
         bo = $urandom;
         apb(1'b1, OFS_CTRL, w);
         apb(1'b1, OFS_LANE_OUT, lo);
         apb(1'b1, OFS_LANE_DIR, ld);
         bus_data_o <= bo;
         bus_data_oe <= w[0];
         settle(1);
         for (int k = 0; k < 4; k++) begin
            eo[8*k+:8] = lane_port(w, k) ? lo[8*k+:8] : bo[8*k+:8];
            eoe[8*k+:8] = lane_port(w, k) ? ld[8*k+:8] : {8{w[0]}};
         end
         chk(data_pins_o, eo);
         chk(data_pins_oe, eoe);
      end
      $display("lane width test done");
      apb(1'b1, OFS_FUNC, 32'h038);
      for (int m = 0; m < 3; m++) begin
         apb(1'b1, OFS_CTRL, {28'h0, m == 2, m == 1, 2'b10});
         write_strobe_n <= 4'($urandom);
         byte_enable_n <= 4'($urandom);
         sdram_mask <= 4'($urandom);
         read_strobe_n <= m[0];
         settle(1);
         sel = (m == 2) ? sdram_mask :
               (m == 1) ? byte_enable_n : write_strobe_n;
         chk({misc_pins_o[5:3], write_strobe_lane3}, sel);
         chk({misc_pins_oe[5:3], read_strobe_pin}, {3'h7, m[0]});
      end
      $display("write strobe test done");
      mo = $urandom;
      md = $urandom;
      apb(1'b1, OFS_FUNC, 32'h0);
      apb(1'b1, OFS_MISC_OUT, mo);
      apb(1'b1, OFS_MISC_DIR, md);
      ext_misc <= 10'($urandom);
      ext_data <= $urandom;
      bus_data_oe <= 1'b0;
      settle(3);
      chk(bus_data_i, ext_data);
      chk(misc_pins_o, mo[9:0]);
      chk(misc_pins_oe, md[9:0]);
      apb(1'b0, OFS_MISC_IN, 32'h0);
      chk(rd, (md[9:0] & mo[9:0]) | (~md[9:0] & ext_misc));
      $display("port mode test done");
      apb(1'b1, OFS_MISC_DIR, 32'h0);
      apb(1'b1, OFS_FUNC, 32'h007);
      bus_released <= 1'b1;
      ext_misc <= 10'h004;
      settle(3);
      chk({misc_pins_oe[1], misc_pins_o[1]}, 2'b10);
      chk(bus_release_req, 1'b1);
      chk(bus_ready, 1'b0);
      @(posedge pclk);
      bus_released <= 1'b0;
      ext_misc <= 10'h001;
      settle(3);
      chk({misc_pins_oe[1], misc_pins_o[1]}, 2'b11);
      chk(bus_release_req, 1'b0);
      chk(bus_ready, 1'b1);
      apb(1'b1, OFS_FUNC, 32'h0);
      ext_misc <= 10'h004;
      settle(3);
      chk(bus_release_req, 1'b0);
      chk(bus_ready, 1'b1);
      chk(misc_pins_oe[1], 1'b0);
      $display("bus release test done");
      apb(1'b1, OFS_FUNC, 32'h1C0);
      mclken_value <= 1'b1;
      settle(2);
      a6 = misc_pins_o[6];
      a8 = misc_pins_o[8];
      settle(1);
      chk({misc_pins_o[8], misc_pins_o[6]}, {~a8, ~a6});
      chk({misc_pins_oe[8:6], misc_pins_o[7]}, 4'hF);
      @(posedge pclk);
      stop_mode <= 1'b1;
      settle(2);
      a8 = misc_pins_o[8];
      settle(1);
      chk({misc_pins_o[8], misc_pins_o[6]}, {~a8, 1'b0});
      @(posedge pclk);
      sleep_mode <= 1'b1;
      settle(2);
      for (int i = 0; i < 4; i++) begin
         chk({misc_pins_o[8], misc_pins_o[6]}, 2'b00);
         settle(1);
      end
      $display("clock output test done");
      conclude();
   end
endmodule
`default_nettype wire
